// [safb_pkg.sv]
package safb_pkg;
    // register offsets on the internal bus
    localparam logic [7:0] SAFB_OFS_DATA = 8'h18;
    localparam logic [7:0] SAFB_OFS_CTRL3 = 8'h16;
    localparam logic [7:0] SAFB_OFS_FLAGS1 = 8'h14;
    localparam logic [7:0] SAFB_OFS_FLAGS2 = 8'h15;
    // fields of serial_ninth_bit_and_fault_enables
    localparam int SAFB_C3_RX9 = 7;
    localparam int SAFB_C3_TX9 = 6;
    localparam int SAFB_C3_OVERRUN_IRQ_EN = 3;
    localparam int SAFB_C3_NOISE_IRQ_EN = 2;
    localparam int SAFB_C3_FRAMING_IRQ_EN = 1;
    localparam int SAFB_C3_PARITY_FAULT_IRQ_EN = 0;
    // fields of serial_flags_primary
    localparam int SAFB_F1_TXE = 7;
    localparam int SAFB_F1_TC = 6;
    localparam int SAFB_F1_RXF = 5;
    localparam int SAFB_F1_IDLE = 4;
    localparam int SAFB_F1_OR = 3;
    localparam int SAFB_F1_NF = 2;
    localparam int SAFB_F1_FE = 1;
    localparam int SAFB_F1_PE = 0;
    // fields of serial_flags_secondary
    localparam int SAFB_F2_BKF = 1;
    localparam int SAFB_F2_RPF = 0;
    localparam logic [7:0] SAFB_F1_RESET = 8'hC0;
    localparam logic [3:0] SAFB_EN_RESET = 4'h0;
    // idle line length in bit times
    localparam int SAFB_IDLE_BITS_SHORT = 10;
    localparam int SAFB_IDLE_BITS_LONG = 11;
endpackage

// [safb_if.sv]
`timescale 1ns/1ps
interface safb_idle_if;
    logic bit_tick;
    logic line_level;
    logic long_char;
    logic arm;
    logic clear;
    logic idle_pulse;
    modport owner (output bit_tick, output line_level, output long_char, output arm, output clear,
                   input idle_pulse);
    modport det (input bit_tick, input line_level, input long_char, input arm, input clear,
                 output idle_pulse);
endinterface

// [safb_idle_det.sv]
`timescale 1ns/1ps
module safb_idle_det
    import safb_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    safb_idle_if.det idl
);
    typedef struct packed {
        logic [3:0] ones;
        logic armed;
        logic pulse;
    } safb_idet_t;
    safb_idet_t st_r, st_nxt;
    logic [3:0] need;

    always_comb begin
        need = idl.long_char ? 4'(SAFB_IDLE_BITS_LONG) : 4'(SAFB_IDLE_BITS_SHORT);
        st_nxt = st_r;
        st_nxt.pulse = 1'b0;
        if (idl.clear) begin
            st_nxt.armed = 1'b0;
        end
        if (idl.arm) begin
            st_nxt.armed = 1'b1;
            st_nxt.ones = 4'h0;
        end
        if (idl.bit_tick) begin
            if (!idl.line_level) begin
                st_nxt.ones = 4'h0;
            end else if (st_r.ones < need) begin
                st_nxt.ones = st_r.ones + 4'h1;
                if (st_r.ones + 4'h1 == need && st_r.armed) begin
                    st_nxt.pulse = 1'b1;
                    st_nxt.armed = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign idl.idle_pulse = st_r.pulse;

    a_idle_needs_arm: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        st_nxt.pulse |-> st_r.armed) else $error("idle set while not armed");
endmodule // safb_idle_det

// [safb_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - nine-bit mode captures received bit 8 with data; eight-bit mode mirrors bit 7.
// - nine-bit mode sends tx_ninth_bit with the eight buffered data bits.
// - reset leaves both ninth bits and data buffer contents unchanged.
// - overrun, noise, framing, parity flags interrupt only when enabled; reset clears enables.
// - buffer-to-shifter transfer sets tx empty flag; interrupts with enable; reset sets.
// - status read with tx empty set, then data write, clears tx empty.
// - done flag sets when tx empty and line quiet; interrupts when enabled; reset sets.
// - queuing data, preamble or break clears done flag automatically.
// - receive transfer sets rx full flag; interrupts when enabled; reset clears.
// - status read with rx full set, then data read, clears rx full.
// - ten or eleven idle bit times set idle flag; interrupts when enabled.
// - idle flag waits for a received character after enable or clear.
// - status read then data read clears the five receive error flags.
// - character completing while buffer full sets overrun and is discarded.
// - data read does not clear overrun if clear at preceding status read.
// - noise and parity faults set their flags; each interrupts when enabled.
// - zero in stop bit sets framing flag; interrupts when enabled.
// - break sets break, framing and rx full flags; clears ninth bit in nine-bit mode.
// - secondary read then data read clears break; rearms only after ones.
// - receive active set by zero in first sample slot; cleared on false start or idle.
// - char_length_select picks eight or nine bit characters.
// - clearing serial_unit_enable sets tx empty and done, masks transmit interrupts.
module safb_top
    import safb_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] bus_addr_in,
    input wire logic bus_rd_in,
    input wire logic bus_wr_in,
    input wire logic [7:0] bus_wdata_in,
    output logic [7:0] bus_rdata_out,
    input wire logic serial_unit_enable_in,
    input wire logic char_length_select_in,
    input wire logic long_idle_in,
    input wire logic tx_empty_irq_en_in,
    input wire logic tx_done_irq_en_in,
    input wire logic rx_full_irq_en_in,
    input wire logic idle_line_irq_en_in,
    input wire logic rx_enable_rise_in,
    input wire logic rx_line_in,
    input wire logic rx_bit_tick_in,
    input wire logic rx_first_slot_zero_in,
    input wire logic rx_false_start_in,
    input wire logic rx_done_in,
    input wire logic [8:0] rx_char_in,
    input wire logic rx_noise_in,
    input wire logic rx_parity_bad_in,
    input wire logic rx_stop_zero_in,
    input wire logic rx_break_in,
    input wire logic tx_shifter_ready_in,
    input wire logic tx_busy_in,
    input wire logic tx_queue_in,
    output logic tx_load_out,
    output logic [8:0] tx_char_out,
    output logic tx_irq_out,
    output logic rx_irq_out,
    output logic err_irq_out
);
    typedef struct packed {
        logic [7:0] rx_data;
        logic rx9;
        logic [7:0] tx_data;
        logic tx9;
        logic tx_pending;
        logic [3:0] en;
        logic txe, tc, rxf, idle, ovr, nf, fe, pe;
        logic break_seen_flag, receive_active_flag, brk_armed;
        logic [7:0] f1_seen;
        logic bkf_seen;
        logic load;
        logic [8:0] tx_char;
        logic [7:0] rdata;
    } safb_state_t;

    safb_state_t st_r, st_nxt;
    safb_idle_if idl ();

    function automatic logic [7:0] flags1(input safb_state_t s);
        logic [7:0] f;
        f = 8'h00;
        f[SAFB_F1_TXE] = s.txe;
        f[SAFB_F1_TC] = s.tc;
        f[SAFB_F1_RXF] = s.rxf;
        f[SAFB_F1_IDLE] = s.idle;
        f[SAFB_F1_OR] = s.ovr;
        f[SAFB_F1_NF] = s.nf;
        f[SAFB_F1_FE] = s.fe;
        f[SAFB_F1_PE] = s.pe;
        return f;
    endfunction

    logic rd_data, wr_data, rd_f1, rd_f2, rd_c3, wr_c3, accept_rx, xfer, clr_rx, idle_clr;
    logic [7:0] c3_view, f2_view;

    assign rd_data = bus_rd_in && bus_addr_in == SAFB_OFS_DATA;
    assign wr_data = bus_wr_in && bus_addr_in == SAFB_OFS_DATA;
    assign rd_f1 = bus_rd_in && bus_addr_in == SAFB_OFS_FLAGS1;
    assign rd_f2 = bus_rd_in && bus_addr_in == SAFB_OFS_FLAGS2;
    assign rd_c3 = bus_rd_in && bus_addr_in == SAFB_OFS_CTRL3;
    assign wr_c3 = bus_wr_in && bus_addr_in == SAFB_OFS_CTRL3;
    assign clr_rx = rd_data;
    // overrun: a finished character is dropped while the buffer is still full
    assign accept_rx = rx_done_in && !st_r.rxf;
    assign xfer = st_r.tx_pending && tx_shifter_ready_in && serial_unit_enable_in;
    assign idle_clr = clr_rx && st_r.f1_seen[SAFB_F1_IDLE] && st_r.idle;

    always_comb begin
        c3_view = 8'h00;
        c3_view[SAFB_C3_RX9] = st_r.rx9;
        c3_view[SAFB_C3_TX9] = st_r.tx9;
        {c3_view[SAFB_C3_OVERRUN_IRQ_EN], c3_view[SAFB_C3_NOISE_IRQ_EN], c3_view[SAFB_C3_FRAMING_IRQ_EN], c3_view[SAFB_C3_PARITY_FAULT_IRQ_EN]} = st_r.en;
        f2_view = 8'h00;
        f2_view[SAFB_F2_BKF] = st_r.break_seen_flag;
        f2_view[SAFB_F2_RPF] = st_r.receive_active_flag;
    end

    assign idl.bit_tick = rx_bit_tick_in;
    assign idl.line_level = rx_line_in;
    assign idl.long_char = long_idle_in;
    assign idl.arm = accept_rx;
    assign idl.clear = idle_clr || rx_enable_rise_in;

    safb_idle_det u_idle (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .idl(idl)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.load = 1'b0;
        // status-read snapshots feed the two-step clear sequences
        if (rd_f1) begin
            st_nxt.f1_seen = flags1(st_r);
        end
        if (rd_f2) begin
            st_nxt.bkf_seen = st_r.break_seen_flag;
        end
        // data read clears only flags that were seen set
        if (clr_rx) begin
            if (st_r.f1_seen[SAFB_F1_RXF]) st_nxt.rxf = 1'b0;
            if (st_r.f1_seen[SAFB_F1_IDLE]) st_nxt.idle = 1'b0;
            if (st_r.f1_seen[SAFB_F1_OR]) st_nxt.ovr = 1'b0;
            if (st_r.f1_seen[SAFB_F1_NF]) st_nxt.nf = 1'b0;
            if (st_r.f1_seen[SAFB_F1_FE]) st_nxt.fe = 1'b0;
            if (st_r.f1_seen[SAFB_F1_PE]) st_nxt.pe = 1'b0;
            if (st_r.bkf_seen) st_nxt.break_seen_flag = 1'b0;
            st_nxt.f1_seen = 8'h00;
            st_nxt.bkf_seen = 1'b0;
        end
        if (wr_data) begin
            st_nxt.tx_data = bus_wdata_in;
            st_nxt.tx_pending = 1'b1;
            if (st_r.f1_seen[SAFB_F1_TXE]) st_nxt.txe = 1'b0;
            st_nxt.f1_seen[SAFB_F1_TXE] = 1'b0;
        end
        if (wr_c3) begin
            st_nxt.tx9 = bus_wdata_in[SAFB_C3_TX9];
            st_nxt.en = {bus_wdata_in[SAFB_C3_OVERRUN_IRQ_EN], bus_wdata_in[SAFB_C3_NOISE_IRQ_EN],
                         bus_wdata_in[SAFB_C3_FRAMING_IRQ_EN], bus_wdata_in[SAFB_C3_PARITY_FAULT_IRQ_EN]};
        end
        // receive side: hardware sets after the clears so a same-cycle event wins
        if (rx_done_in && st_r.rxf) begin
            st_nxt.ovr = 1'b1;
        end
        if (accept_rx) begin
            st_nxt.rx_data = rx_char_in[7:0];
            // ninth bit or a mirror of bit 7
            st_nxt.rx9 = char_length_select_in ? rx_char_in[8] : rx_char_in[7];
            st_nxt.rxf = 1'b1;
            if (rx_noise_in) st_nxt.nf = 1'b1;
            if (rx_parity_bad_in) st_nxt.pe = 1'b1;
            if (rx_stop_zero_in) st_nxt.fe = 1'b1;
        end
        if (rx_break_in && st_r.brk_armed) begin
            st_nxt.break_seen_flag = 1'b1;
            st_nxt.fe = 1'b1;
            st_nxt.rxf = 1'b1;
            st_nxt.brk_armed = 1'b0;
            if (char_length_select_in) st_nxt.rx9 = 1'b0;
        end
        if (rx_bit_tick_in && rx_line_in) begin
            st_nxt.brk_armed = 1'b1;
        end
        if (rx_first_slot_zero_in) begin
            st_nxt.receive_active_flag = 1'b1;
        end else if (rx_false_start_in || idl.idle_pulse) begin
            st_nxt.receive_active_flag = 1'b0;
        end
        if (idl.idle_pulse) begin
            st_nxt.idle = 1'b1;
        end
        // transmit side
        if (xfer) begin
            st_nxt.tx_char = {char_length_select_in ? st_r.tx9 : 1'b1, st_r.tx_data};
            st_nxt.load = 1'b1;
            st_nxt.tx_pending = wr_data;
            st_nxt.txe = 1'b1;
        end
        if (tx_queue_in || xfer) begin
            st_nxt.tc = 1'b0;
        end else if (st_r.txe && !tx_busy_in && !st_r.load) begin
            st_nxt.tc = 1'b1;
        end
        if (!serial_unit_enable_in) begin
            st_nxt.txe = 1'b1;
            st_nxt.tc = 1'b1;
        end
        unique case (1'b1)
            rd_data: st_nxt.rdata = st_r.rx_data;
            rd_f1: st_nxt.rdata = flags1(st_r);
            rd_f2: st_nxt.rdata = f2_view;
            rd_c3: st_nxt.rdata = c3_view;
            default: st_nxt.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            // data buffer and ninth bits keep their contents
            st_r.rx_data <= st_r.rx_data;
            st_r.rx9 <= st_r.rx9;
            st_r.tx_data <= st_r.tx_data;
            st_r.tx9 <= st_r.tx9;
            st_r.tx_char <= st_r.tx_char;
            st_r.tx_pending <= 1'b0;
            st_r.en <= SAFB_EN_RESET;
            {st_r.txe, st_r.tc} <= SAFB_F1_RESET[7:6];
            {st_r.rxf, st_r.idle, st_r.ovr, st_r.nf, st_r.fe, st_r.pe} <= SAFB_F1_RESET[5:0];
            st_r.break_seen_flag <= 1'b0;
            st_r.receive_active_flag <= 1'b0;
            st_r.brk_armed <= 1'b1;
            st_r.f1_seen <= 8'h00;
            st_r.bkf_seen <= 1'b0;
            st_r.load <= 1'b0;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_rdata_out = st_r.rdata;
    assign tx_load_out = st_r.load;
    assign tx_char_out = st_r.tx_char;
    // transmit requests masked while the unit is off
    assign tx_irq_out = serial_unit_enable_in &&
        ((st_r.txe && tx_empty_irq_en_in) || (st_r.tc && tx_done_irq_en_in));
    assign rx_irq_out = st_r.rxf && rx_full_irq_en_in;
    assign err_irq_out = (st_r.ovr && st_r.en[3]) || (st_r.nf && st_r.en[2]) ||
        (st_r.fe && st_r.en[1]) || (st_r.pe && st_r.en[0]) ||
        (st_r.idle && idle_line_irq_en_in);

    sequence s_f1_read_txe;
        rd_f1 && st_r.txe;
    endsequence
    sequence s_data_write;
        wr_data && !xfer && serial_unit_enable_in;
    endsequence

    a_txe_clear_seq: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        s_f1_read_txe ##1 (!bus_wr_in && !bus_rd_in) ##1 s_data_write |=> !st_r.txe)
        else $error("tx empty not cleared by read then write");
    a_rxf_on_accept: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        accept_rx |=> st_r.rxf) else $error("rx full not set on transfer");
    a_overrun_keeps: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (rx_done_in && st_r.rxf && !rx_break_in) |=> st_r.ovr && st_r.rx_data == $past(st_r.rx_data))
        else $error("overrun lost old data");
    a_overrun_keep_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (clr_rx && st_r.ovr && !st_r.f1_seen[SAFB_F1_OR]) |=> st_r.ovr)
        else $error("overrun cleared without being seen");
    a_err_irq_gate: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (st_r.ovr && st_r.en[3]) |-> err_irq_out) else $error("error irq missing");
    a_err_irq_masked: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (st_r.en == 4'h0 && !idle_line_irq_en_in) |-> !err_irq_out) else $error("error irq unmasked");
    a_break_sets: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (rx_break_in && st_r.brk_armed) |=> st_r.break_seen_flag && st_r.fe && st_r.rxf)
        else $error("break flags not set");
    a_tc_on_queue: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (tx_queue_in && serial_unit_enable_in) |=> !st_r.tc) else $error("done flag not cleared");
    a_disable_sets: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        !serial_unit_enable_in |-> !tx_irq_out ##1 (st_r.txe && st_r.tc)) else $error("disable effect missing");
    a_rpf_set: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        rx_first_slot_zero_in |=> st_r.receive_active_flag) else $error("receive active not set");
    a_rx9_mirror: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        (accept_rx && !char_length_select_in) |=> st_r.rx9 == $past(rx_char_in[7]))
        else $error("ninth bit not mirrored");
endmodule // safb_top

// [safb_remote_model.sv]
`timescale 1ns/1ps
module safb_remote_model #(
    parameter int TX_HOLD = 20
) (
    input wire logic clk_in,
    input wire logic tx_load_in,
    input wire logic [8:0] tx_char_in,
    output logic rx_line_out,
    output logic rx_bit_tick_out,
    output logic rx_first_slot_zero_out,
    output logic rx_false_start_out,
    output logic rx_done_out,
    output logic [8:0] rx_char_out,
    output logic rx_noise_out,
    output logic rx_parity_bad_out,
    output logic rx_stop_zero_out,
    output logic rx_break_out,
    output logic tx_shifter_ready_out,
    output logic tx_busy_out,
    output logic tx_queue_out
);
    int cnt = 0;
    int loads = 0;
    logic q_busy = 1'b0;
    logic [8:0] last_tx = '0;
    initial begin
        {rx_bit_tick_out, rx_first_slot_zero_out, rx_false_start_out, rx_done_out} = 4'h0;
        {rx_noise_out, rx_parity_bad_out, rx_stop_zero_out, rx_break_out, tx_queue_out} = 5'h00;
        rx_line_out = 1'b1;
        rx_char_out = '0;
    end
    // shifter stays busy for a whole character after every load
    always @(negedge clk_in) begin
        if (tx_load_in) begin
            last_tx <= tx_char_in;
            loads <= loads + 1;
            cnt <= TX_HOLD;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign tx_busy_out = (cnt != 0) || q_busy;
    assign tx_shifter_ready_out = (cnt == 0);
    task automatic send(input logic [8:0] c, input logic [2:0] err);
        @(negedge clk_in);
        rx_line_out = 1'b0;
        repeat (4) @(negedge clk_in);
        rx_line_out = !err[0];
        rx_done_out = 1'b1;
        rx_char_out = c;
        {rx_noise_out, rx_parity_bad_out, rx_stop_zero_out} = err;
        @(negedge clk_in);
        rx_done_out = 1'b0;
        rx_char_out = ~c;
        {rx_noise_out, rx_parity_bad_out, rx_stop_zero_out} = 3'b000;
        rx_line_out = 1'b1;
    endtask
    task automatic brk();
        @(negedge clk_in);
        rx_line_out = 1'b0;
        repeat (4) @(negedge clk_in);
        rx_break_out = 1'b1;
        @(negedge clk_in);
        rx_break_out = 1'b0;
        rx_line_out = 1'b1;
    endtask
    task automatic ticks(input int n);
        rx_line_out = 1'b1;
        repeat (n) begin
            @(negedge clk_in);
            rx_bit_tick_out = 1'b1;
            @(negedge clk_in);
            rx_bit_tick_out = 1'b0;
        end
    endtask
    task automatic slot(input logic false_start);
        @(negedge clk_in);
        rx_first_slot_zero_out = 1'b1;
        @(negedge clk_in);
        rx_first_slot_zero_out = 1'b0;
        rx_false_start_out = false_start;
        @(negedge clk_in);
        rx_false_start_out = 1'b0;
    endtask
    task automatic queue_start();
        @(negedge clk_in);
        tx_queue_out = 1'b1;
        q_busy = 1'b1;
        @(negedge clk_in);
        tx_queue_out = 1'b0;
    endtask
    task automatic queue_end();
        @(negedge clk_in);
        q_busy = 1'b0;
    endtask
endmodule // safb_remote_model

// [test_serial_async_flags_data_buffer.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_serial_async_flags_data_buffer;
    import safb_pkg::*;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] addr = '0;
    logic [7:0] wdata = '0;
    logic rd_s = 0, wr_s = 0, ena = 1, nine = 0, lng = 0, en_rise = 0, t9 = 0;
    logic ie_t = 1, ie_c = 1, ie_r = 1, ie_i = 1;
    logic line, tick, fsz, fst, done, nz, pb, sz, brk, rdy, busy, queue, load, irq_t, irq_r, irq_e;
    logic [8:0] ch;
    logic [8:0] tch;
    logic [7:0] rdata;
    int bad_count = 0;
    int comparisons = 0;
    always #12.5 ref_clk_in = ~ref_clk_in;
    safb_top DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .bus_addr_in(addr), .bus_rd_in(rd_s),
        .bus_wr_in(wr_s), .bus_wdata_in(wdata), .bus_rdata_out(rdata), .serial_unit_enable_in(ena),
        .char_length_select_in(nine), .long_idle_in(lng), .tx_empty_irq_en_in(ie_t), .tx_done_irq_en_in(ie_c),
        .rx_full_irq_en_in(ie_r), .idle_line_irq_en_in(ie_i), .rx_enable_rise_in(en_rise), .rx_line_in(line),
        .rx_bit_tick_in(tick), .rx_first_slot_zero_in(fsz), .rx_false_start_in(fst), .rx_done_in(done),
        .rx_char_in(ch), .rx_noise_in(nz), .rx_parity_bad_in(pb), .rx_stop_zero_in(sz), .rx_break_in(brk),
        .tx_shifter_ready_in(rdy), .tx_busy_in(busy), .tx_queue_in(queue), .tx_load_out(load),
        .tx_char_out(tch), .tx_irq_out(irq_t), .rx_irq_out(irq_r), .err_irq_out(irq_e));
    safb_remote_model p (.clk_in(ref_clk_in), .tx_load_in(load), .tx_char_in(tch), .rx_line_out(line),
        .rx_bit_tick_out(tick), .rx_first_slot_zero_out(fsz), .rx_false_start_out(fst), .rx_done_out(done),
        .rx_char_out(ch), .rx_noise_out(nz), .rx_parity_bad_out(pb), .rx_stop_zero_out(sz),
        .rx_break_out(brk), .tx_shifter_ready_out(rdy), .tx_busy_out(busy), .tx_queue_out(queue));
    task automatic complete_run();
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(negedge ref_clk_in);
        addr = a;
        rd_s = 1'b1;
        @(negedge ref_clk_in);
        rd_s = 1'b0;
        `CHK($sformatf("reg %h", a), e, rdata & m)
    endtask
    // plain writes only, never read-modify-write on the data location
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge ref_clk_in);
        wr_s = 1'b0;
    endtask
    task automatic c3(input logic [3:0] en);
        wr(SAFB_OFS_CTRL3, {1'b0, t9, 2'b00, en});
    endtask
    task automatic settle(input int n, input logic idl);
        int i;
        for (i = 0; i < 400 && !(p.loads >= n && !(idl && busy)); i++) @(negedge ref_clk_in);
        if (i == 400) begin
            bad_count++;
            complete_run();
        end
    endtask
    initial begin
        repeat (4) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        rd(SAFB_OFS_FLAGS2, 8'h00, 8'h03);
        rd(SAFB_OFS_CTRL3, 8'h00, 8'h0F);
        rd(8'h20, 8'h00);
        nine = 1;
        t9 = 1;
        c3(4'h0);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        wr(SAFB_OFS_DATA, 8'hA5);
        settle(1, 0);
        `CHK("tx char", 9'h1A5, p.last_tx)
        rd(SAFB_OFS_FLAGS1, 8'h80);
        t9 = 0;
        c3(4'h0);
        rd(SAFB_OFS_FLAGS1, 8'h80);
        wr(SAFB_OFS_DATA, 8'h3C);
        rd(SAFB_OFS_FLAGS1, 8'h00);
        `CHK("tx irq", 1'b0, irq_t)
        settle(2, 1);
        `CHK("tx char", 9'h03C, p.last_tx)
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        `CHK("tx irq", 1'b1, irq_t)
        ie_t = 0;
        @(negedge ref_clk_in);
        `CHK("tx irq", 1'b1, irq_t)
        ie_c = 0;
        @(negedge ref_clk_in);
        `CHK("tx irq", 1'b0, irq_t)
        {ie_t, ie_c} = 2'b11;
        p.queue_start();
        rd(SAFB_OFS_FLAGS1, 8'h80);
        p.queue_end();
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        p.send(9'h100, 3'b000);
        rd(SAFB_OFS_CTRL3, 8'h80, 8'h80);
        `CHK("rx irq", 1'b1, irq_r)
        ie_r = 0;
        @(negedge ref_clk_in);
        `CHK("rx irq", 1'b0, irq_r)
        ie_r = 1;
        rd(SAFB_OFS_FLAGS1, 8'hE0);
        rd(SAFB_OFS_DATA, 8'h00);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        nine = 0;
        p.send(9'h080, 3'b000);
        rd(SAFB_OFS_CTRL3, 8'h80, 8'h80);
        rd(SAFB_OFS_FLAGS1, 8'hE0);
        rd(SAFB_OFS_DATA, 8'h80);
        p.send(9'h17F, 3'b000);
        rd(SAFB_OFS_CTRL3, 8'h00, 8'h80);
        rd(SAFB_OFS_FLAGS1, 8'hE0);
        rd(SAFB_OFS_DATA, 8'h7F);
        p.send(9'h011, 3'b000);
        p.send(9'h022, 3'b000);
        rd(SAFB_OFS_FLAGS1, 8'hE8);
        c3(4'h8);
        `CHK("err irq", 1'b1, irq_e)
        c3(4'h0);
        rd(SAFB_OFS_DATA, 8'h11);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        p.send(9'h033, 3'b000);
        rd(SAFB_OFS_FLAGS1, 8'hE0);
        p.send(9'h044, 3'b000);
        rd(SAFB_OFS_DATA, 8'h33);
        rd(SAFB_OFS_FLAGS1, 8'hC8);
        rd(SAFB_OFS_DATA, 8'h33);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        p.send(9'h055, 3'b111);
        rd(SAFB_OFS_FLAGS1, 8'hE7);
        `CHK("err irq", 1'b0, irq_e)
        for (int i = 0; i < 4; i++) begin
            c3(4'(1 << i));
            `CHK("err irq", logic'(i < 3), irq_e)
        end
        c3(4'h0);
        rd(SAFB_OFS_DATA, 8'h55);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        nine = 1;
        p.send(9'h1FF, 3'b000);
        rd(SAFB_OFS_FLAGS1, 8'hE0);
        rd(SAFB_OFS_DATA, 8'hFF);
        p.brk();
        rd(SAFB_OFS_FLAGS1, 8'hE2);
        rd(SAFB_OFS_CTRL3, 8'h00, 8'h80);
        `CHK("err irq", 1'b0, irq_e)
        rd(SAFB_OFS_FLAGS2, 8'h02, 8'h02);
        rd(SAFB_OFS_DATA, 8'h00, 8'h00);
        rd(SAFB_OFS_FLAGS2, 8'h00, 8'h02);
        rd(SAFB_OFS_FLAGS1, 8'h00, 8'h00);
        rd(SAFB_OFS_DATA, 8'h00, 8'h00);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        en_rise = 1;
        @(negedge ref_clk_in);
        en_rise = 0;
        p.ticks(12);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        p.send(9'h066, 3'b000);
        rd(SAFB_OFS_FLAGS1, 8'hE0);
        rd(SAFB_OFS_DATA, 8'h66);
        p.slot(0);
        rd(SAFB_OFS_FLAGS2, 8'h01, 8'h01);
        lng = 1;
        p.ticks(10);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        p.ticks(1);
        rd(SAFB_OFS_FLAGS1, 8'hD0);
        `CHK("err irq", 1'b1, irq_e)
        ie_i = 0;
        @(negedge ref_clk_in);
        `CHK("err irq", 1'b0, irq_e)
        ie_i = 1;
        rd(SAFB_OFS_FLAGS2, 8'h00, 8'h01);
        rd(SAFB_OFS_DATA, 8'h00, 8'h00);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        p.ticks(11);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        lng = 0;
        p.send(9'h177, 3'b000);
        rd(SAFB_OFS_FLAGS1, 8'hE0);
        rd(SAFB_OFS_DATA, 8'h77);
        p.ticks(10);
        rd(SAFB_OFS_FLAGS1, 8'hD0);
        rd(SAFB_OFS_DATA, 8'h00, 8'h00);
        p.slot(1);
        rd(SAFB_OFS_FLAGS2, 8'h00, 8'h01);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        wr(SAFB_OFS_DATA, 8'h11);
        settle(3, 0);
        rd(SAFB_OFS_FLAGS1, 8'h80);
        wr(SAFB_OFS_DATA, 8'h22);
        ena = 0;
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        `CHK("tx irq", 1'b0, irq_t)
        ena = 1;
        settle(3, 1);
        repeat (3) @(negedge ref_clk_in);
        settle(3, 1);
        p.send(9'h1C3, 3'b000);
        rd(SAFB_OFS_FLAGS1, 8'hE0);
        rd(SAFB_OFS_DATA, 8'hC3);
        t9 = 1;
        c3(4'hF);
        sys_rst_in = 1'b1;
        repeat (4) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        rd(SAFB_OFS_CTRL3, 8'hC0, 8'hCF);
        rd(SAFB_OFS_DATA, 8'hC3);
        rd(SAFB_OFS_FLAGS1, 8'hC0);
        complete_run();
    end
endmodule // test_serial_async_flags_data_buffer
